// file: hw/brc_regs.sv
// Purpose: registers and local SRAM controller of the bit rotation unit
// Assumes: one clock; the slow internal rate is an enable from a divider
// Notes:   packer bit picking and DMA programming live outside this block
// Contract
// - during rotation, system interface SRAM accesses are refused
// - fetcher only writes SRAM, packer only reads it
// - fetcher and packer share SRAM under rotating priority
// - operation registers at 01FF8060h..01FF8063h
// - setup registers at 01FF8870h..01FF8875h
// - registers and fetcher on fast rate, SRAM and packer on slow, synchronised
// - writing one to bit 15 of control starts rotation
// - bit 15 reads busy while rotating
// - swath end clears busy and resets rotation circuits, not registers
// - writing go from one to zero resets the rotation unit
// - control bit 3 selects odd-first or even-first packing
// - packed halfwords fill from bit 15, partial tail in top bits
// - control bit 2 reads one after a print underrun
// - control bit 1 mirrors packed halfword ready
// - ready clears after packed read and on go falling edge
// - control bit 0 is shuttle direction, one is right to left
// - line length bits 10..0 hold bytes minus one
// - packed halfword register at 01FF8062h feeds DMA channel 2
// - warp programmable in 32-byte steps up to 4064 bytes
// - nozzle count register at 01FF8870h feeds the packer
// - nozzle count bits 7..0 hold nozzles minus one
// - warp bits 11..5 hold jump size directly
// - idle: system interface alone reaches SRAM at 01FF9000h..01FF93FFh
// - fetcher and packer never use the same bank at once
`timescale 1ns/1ps
`default_nettype none
module brc_regs
    import brc_pkg::*;
(
    input  wire logic                 clk_i,          // system interface clock
    input  wire logic                 rstn_i,         // async reset, active low
    input  wire logic                 sys_wr_i,       // halfword write strobe
    input  wire logic                 sys_rd_i,       // halfword read strobe
    input  wire logic [31:0]          sys_addr_i,     // byte address
    input  wire logic [15:0]          sys_wdata_i,    // write data
    output logic      [15:0]          sys_rdata_o,    // read data
    output logic                      sys_ack_o,      // access done pulse
    input  wire brc_pkg::brc_mreq_t   fetch_i,        // fetcher write request
    output logic                      fetch_ack_o,    // fetcher write done
    input  wire brc_pkg::brc_mreq_t   pack_i,         // packer read request
    output logic                      pack_ack_o,     // packer read done
    output logic      [15:0]          pack_rdata_o,   // packer read data
    input  wire logic                 pack_push_i,    // packer word ready
    input  wire logic [15:0]          pack_word_i,    // packed halfword
    input  wire logic                 swath_done_i,   // packer end of swath
    input  wire logic                 underrun_i,     // packer underrun event
    output brc_pkg::brc_cfg_t         cfg_o,          // settings for packer
    output logic                      busy_slow_o,    // busy seen on slow side
    output logic                      ihs_en_o,       // slow-rate enable
    output logic                      rot_rst_o,      // rotation circuit reset pulse
    output logic                      ready_o         // packed halfword ready
);
    import brc_pkg::*;

    logic [15:0]        mem [BRC_SRAM_WORDS];
    logic               go_reg, order_reg, dir_reg, under_reg, ready_reg;
    logic [7:0]         noz_reg;
    logic [6:0]         warp_reg;
    logic [10:0]        line_reg;
    logic [15:0]        pack_reg;
    logic [15:0]        rdata_reg, prdata_reg;
    logic               ack_reg, fack_reg, pack_reg_ack;
    logic               ihs_en_reg, busy_s1_reg, busy_s2_reg, rst_reg;
    logic               last_pack_reg;
    logic [$clog2(BRC_IHS_DIV)-1:0] div_reg;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
        hit = (a[31:1] == base[31:1]);
    endfunction

    wire sel_ctrl   = hit(sys_addr_i, BRC_CTRL_ADDR);
    wire sel_pack   = hit(sys_addr_i, BRC_PACK_ADDR);
    wire sel_noz    = hit(sys_addr_i, BRC_NOZZLE_ADDR);
    wire sel_warp   = hit(sys_addr_i, BRC_WARP_ADDR);
    wire sel_line   = hit(sys_addr_i, BRC_LINE_ADDR);
    wire sel_sram   = (sys_addr_i >= BRC_SRAM_BASE) && (sys_addr_i <= BRC_SRAM_LAST);
    wire [BRC_AW-1:0] sys_word = sys_addr_i[BRC_AW:1];

    wire wr_ctrl    = sys_wr_i && sel_ctrl;
    wire go_rise    = wr_ctrl && sys_wdata_i[BRC_GO_BIT] && !go_reg;
    wire go_fall    = wr_ctrl && !sys_wdata_i[BRC_GO_BIT] && go_reg;
    wire rot_reset  = go_fall || (swath_done_i && go_reg);
    wire pack_read  = sys_rd_i && sel_pack;
    wire setup_ok   = sys_wr_i && !go_reg;

    // slow-rate enable; SRAM controller and packer side advance only on it
    wire ihs_tick   = (div_reg == '0);

    // sram access: system interface only while idle, else fetcher/packer
    wire sys_mem    = sel_sram && (sys_wr_i || sys_rd_i) && !busy_s2_reg;
    wire f_req      = fetch_i.req && busy_s2_reg && !fack_reg;
    wire p_req      = pack_i.req && busy_s2_reg && !pack_reg_ack;
    wire same_bank  = fetch_i.addr[BRC_BANK_BIT] == pack_i.addr[BRC_BANK_BIT];
    // after reset the packer wins a first tie; the fetcher wins once the packer was served
    // one port per slow tick, so the two never touch a bank together
    wire pick_fetch = f_req && (!p_req || last_pack_reg);
    wire pick_pack  = p_req && !pick_fetch;

    brc_gnt_t gnt;
    assign gnt = !ihs_tick   ? BRC_GNT_NONE :
                 sys_mem     ? BRC_GNT_SYS  :
                 pick_fetch  ? BRC_GNT_FETCH :
                 pick_pack   ? BRC_GNT_PACK  : BRC_GNT_NONE;

    wire [15:0] ctrl_rd = {go_reg, 11'h000, order_reg, under_reg, ready_reg, dir_reg};
    wire [15:0] reg_rd  = sel_ctrl ? ctrl_rd :
                          sel_pack ? pack_reg :
                          sel_noz  ? {8'h00, noz_reg} :
                          sel_warp ? {4'h0, warp_reg, 5'h00} :
                          sel_line ? {5'h00, line_reg} : BRC_RST_HALF;

    // idle system interface memory accesses wait for a slow tick before acking
    wire sys_done   = (sys_wr_i || sys_rd_i) && (!sys_mem || gnt == BRC_GNT_SYS) && !ack_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= (div_reg == $clog2(BRC_IHS_DIV)'(BRC_IHS_DIV - 1)) ? '0 : div_reg + 1'b1;
        end
    end

    // busy passes two slow-side stages before it steers the SRAM controller
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
        end else if (ihs_tick) begin
            busy_s1_reg <= go_reg;
            busy_s2_reg <= busy_s1_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            go_reg    <= 1'b0;
            order_reg <= 1'b0;
            dir_reg   <= 1'b0;
        end else if (wr_ctrl) begin
            go_reg    <= sys_wdata_i[BRC_GO_BIT];
            order_reg <= sys_wdata_i[BRC_ORDER_BIT];
            dir_reg   <= sys_wdata_i[BRC_DIR_BIT];
        end else if (swath_done_i) begin
            go_reg    <= 1'b0;
        end
    end

    // setup values are frozen during a rotation so the packer sees stable values
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            noz_reg  <= '0;
            warp_reg <= '0;
            line_reg <= '0;
        end else if (setup_ok) begin
            if (sel_noz)  noz_reg  <= sys_wdata_i[BRC_NOZ_MSB:0];
            if (sel_warp) warp_reg <= sys_wdata_i[BRC_WARP_MSB:BRC_WARP_LSB];
            if (sel_line) line_reg <= sys_wdata_i[BRC_LINE_MSB:0];
        end
    end

    // set beats clear; rotation reset wins over both
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_reg <= 1'b0;
            under_reg <= 1'b0;
            pack_reg  <= BRC_RST_HALF;
        end else if (rot_reset || go_rise) begin
            ready_reg <= 1'b0;
            under_reg <= go_rise ? 1'b0 : under_reg && !go_fall;
        end else begin
            if (pack_push_i) begin
                ready_reg <= 1'b1;
                pack_reg  <= pack_word_i;
            end else if (pack_read) begin
                ready_reg <= 1'b0;
            end
            if (underrun_i && go_reg) under_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (gnt == BRC_GNT_SYS && sys_wr_i) mem[sys_word] <= sys_wdata_i;
        if (gnt == BRC_GNT_FETCH) mem[fetch_i.addr] <= fetch_i.data;
    end

    // refused sram reads still ack, with zero data, so a polling master never hangs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg     <= BRC_RST_HALF;
            prdata_reg    <= BRC_RST_HALF;
            ack_reg       <= 1'b0;
            fack_reg      <= 1'b0;
            pack_reg_ack  <= 1'b0;
            last_pack_reg <= 1'b0;
            ihs_en_reg    <= 1'b0;
            rst_reg       <= 1'b0;
        end else begin
            ack_reg      <= sys_done;
            fack_reg     <= gnt == BRC_GNT_FETCH;
            pack_reg_ack <= gnt == BRC_GNT_PACK;
            ihs_en_reg   <= ihs_tick;
            rst_reg      <= rot_reset;
            if (sys_done && sys_rd_i) rdata_reg <= sel_sram ? (sys_mem ? mem[sys_word] : BRC_RST_HALF) : reg_rd;
            if (gnt == BRC_GNT_PACK) prdata_reg <= mem[pack_i.addr];
            if (rot_reset) last_pack_reg <= 1'b0;
            else if (gnt == BRC_GNT_FETCH) last_pack_reg <= 1'b0;
            else if (gnt == BRC_GNT_PACK) last_pack_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) cfg_o <= '0;
        else cfg_o <= '{nozzle_count_field: noz_reg, warp_field: warp_reg, line_length_field: line_reg,
                        dir: dir_reg, order: order_reg};
    end

    assign sys_rdata_o  = rdata_reg;
    assign sys_ack_o    = ack_reg;
    assign fetch_ack_o  = fack_reg;
    assign pack_ack_o   = pack_reg_ack;
    assign pack_rdata_o = prdata_reg;
    assign busy_slow_o  = busy_s2_reg;
    assign ihs_en_o     = ihs_en_reg;
    assign rot_rst_o    = rst_reg;
    assign ready_o      = ready_reg;

    sequence s_go_written;
        wr_ctrl && sys_wdata_i[BRC_GO_BIT] && !swath_done_i;
    endsequence
    sequence s_busy_seen;
        go_reg ##1 go_reg;
    endsequence

    sram_lockout_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        busy_s2_reg |-> gnt != BRC_GNT_SYS) else $error("system access granted while busy");
    arb_rotate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ihs_tick && f_req && p_req && last_pack_reg) |-> gnt == BRC_GNT_FETCH)
        else $error("fetcher not granted after packer");
    arb_fair_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (gnt == BRC_GNT_PACK && !rot_reset) ##1 !rot_reset ##1 (ihs_tick && f_req && p_req)
            |-> gnt == BRC_GNT_FETCH)
        else $error("packer served twice in a row");
    start_busy_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_go_written |=> ctrl_rd[BRC_GO_BIT]) else $error("start did not set busy");
    done_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (swath_done_i && !wr_ctrl) |=> !go_reg && rot_rst_o == $past(go_reg))
        else $error("swath end did not clear busy");
    fall_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (s_busy_seen ##0 go_fall) |=> !ready_reg && !under_reg && rst_reg)
        else $error("go falling edge did not reset");
    ready_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (pack_read && !pack_push_i) |=> !ready_o) else $error("ready not cleared by read");
    ready_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (pack_push_i && !rot_reset && !go_rise) |=>
            ready_o && ctrl_rd[BRC_READY_BIT] && pack_reg == $past(pack_word_i))
        else $error("ready not set by packed word");
    under_sticky_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (underrun_i && go_reg && !rot_reset && !go_rise) |=>
            under_reg ##1 (under_reg || $past(rot_reset || go_rise)))
        else $error("underrun flag lost");

    // sram grant bound below assumes a slow tick every second cycle
    sequence s_sys_mem_req;
        sel_sram && (sys_wr_i || sys_rd_i) && !busy_s2_reg && !ack_reg;
    endsequence
    sequence s_sys_granted;
        gnt == BRC_GNT_SYS;
    endsequence

    idle_access_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_sys_mem_req |-> ##[0:1] s_sys_granted)
        else $error("idle system sram access not granted");
    refused_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (sys_rd_i && sel_sram && busy_s2_reg && !ack_reg) |=> sys_ack_o && sys_rdata_o == BRC_RST_HALF)
        else $error("sram read during rotation not refused");
    one_port_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (f_req && p_req && same_bank) |=> !(fetch_ack_o && pack_ack_o))
        else $error("both requesters served at once");
    rotation_only_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (gnt == BRC_GNT_FETCH || gnt == BRC_GNT_PACK) |-> busy_s2_reg && ihs_tick)
        else $error("requester served outside a rotation");
    fetch_ack_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (gnt == BRC_GNT_FETCH) |=> fetch_ack_o && !pack_ack_o)
        else $error("fetcher grant not acknowledged alone");
    grant_taken_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ihs_tick && !sys_mem && (f_req || p_req)) |-> gnt != BRC_GNT_NONE)
        else $error("pending requester left without grant");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sys_ack_o |=> !sys_ack_o)
        else $error("access acknowledge longer than one cycle");
    setup_frozen_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (go_reg && sys_wr_i && (sel_noz || sel_warp || sel_line)) |=>
            {noz_reg, warp_reg, line_reg} == $past({noz_reg, warp_reg, line_reg}))
        else $error("setup changed during rotation");
    start_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        go_rise |=> !under_reg && !ready_reg)
        else $error("start did not clear status");
    busy_stage_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(busy_s2_reg) |-> $past(busy_s1_reg) && $past(ihs_tick))
        else $error("busy skipped a synchroniser stage");
endmodule
`default_nettype wire

// file: hw/brc_pkg.sv
// Purpose: shared constants and types for the bit rotation control block
// Assumes: halfword register accesses on the system interface
// Notes:   byte addresses are the printed ones; bit 0 of an address is ignored
package brc_pkg;
    localparam logic [31:0] BRC_CTRL_ADDR   = 32'h01FF_8060;
    localparam logic [31:0] BRC_PACK_ADDR   = 32'h01FF_8062;
    localparam logic [31:0] BRC_NOZZLE_ADDR = 32'h01FF_8870;
    localparam logic [31:0] BRC_WARP_ADDR   = 32'h01FF_8872;
    localparam logic [31:0] BRC_LINE_ADDR   = 32'h01FF_8874;
    localparam logic [31:0] BRC_SRAM_BASE   = 32'h01FF_9000;
    localparam logic [31:0] BRC_SRAM_LAST   = 32'h01FF_93FF;
    localparam int          BRC_GO_BIT      = 15;
    localparam int          BRC_ORDER_BIT   = 3;
    localparam int          BRC_UNDER_BIT   = 2;
    localparam int          BRC_READY_BIT   = 1;
    localparam int          BRC_DIR_BIT     = 0;
    localparam int          BRC_LINE_MSB    = 10;
    localparam int          BRC_NOZ_MSB     = 7;
    localparam int          BRC_WARP_MSB    = 11;
    localparam int          BRC_WARP_LSB    = 5;
    localparam int          BRC_SRAM_WORDS  = 512;
    localparam int          BRC_AW          = 9;
    localparam int          BRC_BANK_BIT    = 8;
    localparam int          BRC_IHS_DIV     = 2;
    localparam logic [15:0] BRC_RST_HALF    = 16'h0000;

    typedef struct packed {
        logic [7:0]  nozzle_count_field;
        logic [6:0]  warp_field;
        logic [10:0] line_length_field;
        logic        dir;
        logic        order;
    } brc_cfg_t;

    typedef struct packed {
        logic                req;
        logic [BRC_AW-1:0]   addr;
        logic [15:0]         data;
    } brc_mreq_t;

    typedef enum logic [1:0] { BRC_GNT_NONE, BRC_GNT_SYS, BRC_GNT_FETCH, BRC_GNT_PACK } brc_gnt_t;
endpackage

// file: verification/brc_req_model.sv
// Purpose: fetcher and packer requesters facing the local SRAM controller
// Assumes: each request is held until its acknowledge is seen at an edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module brc_req_model (
    input  wire logic          clk_i,        // system clock
    output brc_pkg::brc_mreq_t fetch_o,      // fetcher request
    output brc_pkg::brc_mreq_t pack_o,       // packer request
    input  wire logic          fetch_ack_i,  // fetcher done
    input  wire logic          pack_ack_i,   // packer done
    input  wire logic [15:0]   pack_rdata_i  // packer read data
);
    import brc_pkg::*;
    initial begin
        fetch_o = '0;
        pack_o = '0;
    end
    // fetcher only writes, packer only reads; a tie uses whichever banks fa and pa select
    task automatic run(input logic f, input logic p, input logic [8:0] fa, input logic [15:0] fd,
                       input logic [8:0] pa, output logic pack_first, output logic [15:0] q);
        int n;
        logic fw, pw, fs, ps;
        fw = f;
        pw = p;
        pack_first = 1'b0;
        n = 0;
        @(posedge clk_i);
        fetch_o <= '{req: f, addr: fa, data: fd};
        pack_o <= '{req: p, addr: pa, data: ~fd};
        while ((fw || pw) && n < 40) begin
            @(negedge clk_i);
            n++;
            fs = (fetch_ack_i === 1'b1);
            ps = (pack_ack_i === 1'b1);
            if (ps && fw) pack_first = 1'b1;
            if (ps) q = pack_rdata_i;
            @(posedge clk_i);
            if (fs) begin
                fetch_o <= '{req: 1'b0, addr: ~fa, data: ~fd};
                fw = 1'b0;
            end
            if (ps) begin
                pack_o <= '{req: 1'b0, addr: ~pa, data: fd};
                pw = 1'b0;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: verification/tb_brc_regs.sv
// Purpose: self-checking bench for the bit rotation registers
// Assumes: halfword accesses held until sys_ack_o
// Notes:   packer datapath is outside, so packed words are injected
`timescale 1ns/1ps
`default_nettype none
module tb_brc_regs;
    import brc_pkg::*;
    logic        clk_i, rstn_i, sys_wr_i, sys_rd_i, pack_push_i, swath_done_i, underrun_i;
    logic [31:0] sys_addr_i;
    logic [15:0] sys_wdata_i, pack_word_i, sys_rdata_o, pack_rdata_o, q, n_tick;
    logic        sys_ack_o, fetch_ack_o, pack_ack_o, busy_slow_o, ihs_en_o, rot_rst_o, ready_o, pf;
    brc_mreq_t   fetch_i, pack_i;
    brc_cfg_t    cfg_o;
    logic        rst_seen = 1'b0;
    int          fails = 0, checked = 0, cyc = 0;
    brc_regs brc_regs_i (.clk_i(clk_i), .rstn_i(rstn_i), .sys_wr_i(sys_wr_i), .sys_rd_i(sys_rd_i),
        .sys_addr_i(sys_addr_i), .sys_wdata_i(sys_wdata_i), .sys_rdata_o(sys_rdata_o), .sys_ack_o(sys_ack_o),
        .fetch_i(fetch_i), .fetch_ack_o(fetch_ack_o), .pack_i(pack_i), .pack_ack_o(pack_ack_o),
        .pack_rdata_o(pack_rdata_o), .pack_push_i(pack_push_i), .pack_word_i(pack_word_i),
        .swath_done_i(swath_done_i), .underrun_i(underrun_i), .cfg_o(cfg_o), .busy_slow_o(busy_slow_o),
        .ihs_en_o(ihs_en_o), .rot_rst_o(rot_rst_o), .ready_o(ready_o));
    brc_req_model brc_req_model_i (.clk_i(clk_i), .fetch_o(fetch_i), .pack_o(pack_i),
        .fetch_ack_i(fetch_ack_o), .pack_ack_i(pack_ack_o), .pack_rdata_i(pack_rdata_o));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(negedge clk_i) if (rot_rst_o === 1'b1) rst_seen = 1'b1;
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        sys_wr_i <= wr;
        sys_rd_i <= ~wr;
        sys_addr_i <= a;
        sys_wdata_i <= d;
        do begin
            @(negedge clk_i);
            n++;
        end while (sys_ack_o !== 1'b1 && n < 50);
        q = sys_rdata_o;
        if (n >= 50) fails++;
        @(posedge clk_i);
        sys_wr_i <= 1'b0;
        sys_rd_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        check($sformatf("read %h", a), q, exp);
    endtask
    task automatic strobe(input logic [2:0] s);
        @(posedge clk_i);
        {pack_push_i, underrun_i, swath_done_i} <= s;
        @(posedge clk_i);
        {pack_push_i, underrun_i, swath_done_i} <= 3'b000;
    endtask
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (busy_slow_o !== v && n < 20);
        check("busy_slow", {15'h0000, busy_slow_o}, {15'h0000, v});
    endtask
    initial begin
        {rstn_i, sys_wr_i, sys_rd_i, pack_push_i, swath_done_i, underrun_i} = 6'h00;
        sys_addr_i = 32'h0000_0000;
        sys_wdata_i = 16'h0000;
        pack_word_i = 16'h1234;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdchk(BRC_CTRL_ADDR, 16'h0000);
        rdchk(BRC_PACK_ADDR, 16'h0000);
        rdchk(BRC_NOZZLE_ADDR, 16'h0000);
        rdchk(BRC_WARP_ADDR, 16'h0000);
        n_tick = 16'h0000;
        repeat (8) begin
            @(negedge clk_i);
            n_tick = n_tick + {15'h0000, ihs_en_o};
        end
        check("slow enables", n_tick, 16'(8 / BRC_IHS_DIV));
        bus(1'b1, BRC_NOZZLE_ADDR, 16'h0037);
        bus(1'b1, BRC_WARP_ADDR, 16'hFFFF);
        bus(1'b1, BRC_LINE_ADDR, 16'hFFFF);
        rdchk(BRC_NOZZLE_ADDR, 16'h0037);
        rdchk(BRC_WARP_ADDR, 16'h0FE0);
        rdchk(BRC_LINE_ADDR, 16'h07FF);
        rdchk(32'h01FF_8064, 16'h0000);
        rdchk(32'h01FF_8876, 16'h0000);
        bus(1'b1, BRC_SRAM_BASE + 32'h0000_0002, 16'hC3C3);
        bus(1'b1, BRC_SRAM_LAST - 32'h0000_0001, 16'h0F0F);
        rdchk(BRC_SRAM_BASE + 32'h0000_0002, 16'hC3C3);
        rdchk(BRC_SRAM_LAST - 32'h0000_0001, 16'h0F0F);
        bus(1'b1, BRC_CTRL_ADDR, 16'h8009);
        wait_busy(1'b1);
        rdchk(BRC_CTRL_ADDR, 16'h8009);
        check("cfg", {6'h00, cfg_o.order, cfg_o.dir, cfg_o.nozzle_count_field}, 16'h0337);
        check("cfg warp", {9'h000, cfg_o.warp_field}, 16'h007F);
        check("cfg line", {5'h00, cfg_o.line_length_field}, 16'h07FF);
        rdchk(BRC_SRAM_BASE + 32'h0000_0002, 16'h0000);
        bus(1'b1, BRC_SRAM_BASE + 32'h0000_0002, 16'h5555);
        bus(1'b1, BRC_NOZZLE_ADDR, 16'h00AA);
        rdchk(BRC_NOZZLE_ADDR, 16'h0037);
        brc_req_model_i.run(1'b1, 1'b0, 9'h005, 16'hA5A5, 9'h000, pf, q);
        brc_req_model_i.run(1'b0, 1'b1, 9'h000, 16'h0000, 9'h005, pf, q);
        check("packer data", q, 16'hA5A5);
        brc_req_model_i.run(1'b1, 1'b0, 9'h105, 16'h5A5A, 9'h000, pf, q);
        // fetcher served last, so the packer must win the tie
        brc_req_model_i.run(1'b1, 1'b1, 9'h006, 16'h1111, 9'h105, pf, q);
        check("tie packer first", {15'h0000, pf}, 16'h0001);
        check("tie packer data", q, 16'h5A5A);
        strobe(3'b100);
        @(negedge clk_i);
        check("ready", {15'h0000, ready_o}, 16'h0001);
        strobe(3'b010);
        rdchk(BRC_CTRL_ADDR, 16'h800F);
        rdchk(BRC_PACK_ADDR, 16'h1234);
        repeat (2) @(negedge clk_i);
        check("ready after read", {15'h0000, ready_o}, 16'h0000);
        rst_seen = 1'b0;
        strobe(3'b001);
        repeat (4) @(negedge clk_i);
        check("swath reset", {15'h0000, rst_seen}, 16'h0001);
        wait_busy(1'b0);
        rdchk(BRC_CTRL_ADDR, 16'h000D);
        rdchk(BRC_SRAM_BASE + 32'h0000_000A, 16'hA5A5);
        rdchk(BRC_SRAM_BASE + 32'h0000_0002, 16'hC3C3);
        rdchk(BRC_SRAM_BASE + 32'h0000_000C, 16'h1111);
        bus(1'b1, BRC_CTRL_ADDR, 16'h8000);
        wait_busy(1'b1);
        strobe(3'b100);
        repeat (2) @(negedge clk_i);
        check("ready again", {15'h0000, ready_o}, 16'h0001);
        rst_seen = 1'b0;
        bus(1'b1, BRC_CTRL_ADDR, 16'h0000);
        repeat (4) @(negedge clk_i);
        check("ready on go fall", {15'h0000, ready_o}, 16'h0000);
        check("go fall reset", {15'h0000, rst_seen}, 16'h0001);
        rdchk(BRC_CTRL_ADDR, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
